// [sew_engine.sv]
// Serial EEPROM word engine: three-wire slave, command decode, array.
// Assumes link_clk is the master's serial clock, stopped at will;
// chip_select and serial_data_in are set up to its rising edge.
`timescale 1ns/1ns
`default_nettype none
`include "sew_regs.svh"

module sew_engine
	import sew_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `SEW_WRITE_CYC,
	parameter int unsigned ERASE_CYCLES = `SEW_ERASE_CYC,
	parameter int unsigned ALL_CYCLES   = `SEW_ALL_CYC
)(
	// System clock and reset
	input  wire logic mclk,
	input  wire logic arst_n,
	// Serial link
	input  wire logic link_clk,
	input  wire logic chip_select,
	input  wire logic serial_data_in,
	// Data out pin
	output logic      serial_data_out,
	output logic      serial_data_oe
);

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (WRITE_CYCLES < `SEW_WORDS + 1 || ERASE_CYCLES < `SEW_WORDS + 1 ||
	    ALL_CYCLES < `SEW_WORDS + 1 || ALL_CYCLES > (1 << `SEW_TMR_W) ||
	    WRITE_CYCLES > (1 << `SEW_TMR_W) ||
	    ERASE_CYCLES > (1 << `SEW_TMR_W)) begin : g_bad_cycles
		$error("sew_engine: cycle counts outside timer range");
	end

	// ----------------------------------------
	// State types
	// ----------------------------------------
	// Link control, cleared while select is low
	typedef struct packed {
		sew_lstate_t         lstate;
		logic [4:0]          cnt;
		logic [7:0]          head;
		logic [`SEW_DW-1:0]  data;
	} sew_link_t;

	// Link words handed to the core, kept across select low
	typedef struct packed {
		logic                rd_tgl;
		logic                cmd_tgl;
		logic                adv_tgl;
		logic [1:0]          opc;
		logic [`SEW_AW-1:0]  addr;
		logic [`SEW_DW-1:0]  data;
	} sew_hold_t;

	// Core on the system clock
	typedef struct packed {
		logic [3:0]          s1;
		logic [3:0]          s2;
		logic [3:0]          s3;
		logic                prog_en;
		logic                busy;
		sew_tmr_t            timer;
		logic [6:0]          sweep;
		logic                mem_we;
		logic [`SEW_AW-1:0]  mem_addr;
		logic [`SEW_DW-1:0]  mem_wdata;
		sew_rphase_t         rphase;
		logic [4:0]          rcnt;
		logic [`SEW_DW-1:0]  shift;
		logic                stat_armed;
		logic                stat_show;
		logic                dout;
		logic                doe;
	} sew_core_t;

	sew_link_t           lk;
	sew_link_t           next_lk;
	sew_hold_t           hd;
	sew_hold_t           next_hd;
	sew_core_t           c;
	sew_core_t           next_c;
	logic                lrst_n;
	logic [`SEW_DW-1:0]  mem_rdata;
	sew_op_t             head_op;
	sew_op_t             cmd_op;
	logic [3:0]          ev;
	logic                cs_on;
	logic                cs_rise;
	logic                cs_fall;

	// ----------------------------------------
	// Link domain
	// ----------------------------------------
	// Select low acts as reset of the link control
	assign lrst_n = arst_n & chip_select;

	// Header decode from held bits only, the incoming address bit not needed, no loop through next_lk
	assign head_op = sew_decode(lk.head[6:5], lk.head[4:3]);

	// Instruction shifter, one step per rising link edge
	always_comb begin
		next_lk = lk;
		next_hd = hd;
		unique case (lk.lstate)
			SEW_L_IDLE: begin
				// Only a high data bit leaves idle
				if (serial_data_in) begin
					next_lk.lstate = SEW_L_HEAD;
					next_lk.cnt    = 5'h00;
				end
			end
			SEW_L_HEAD: begin
				// Opcode then address, sampled on rising edge
				next_lk.head = {lk.head[6:0], serial_data_in};
				next_lk.cnt  = lk.cnt + 5'h01;
				if (lk.cnt == 5'(`SEW_HEAD_BITS - 1)) begin
					next_lk.cnt  = 5'h00;
					next_hd.opc  = next_lk.head[7:6];
					next_hd.addr = next_lk.head[5:0];
					unique case (head_op)
						OP_READ: begin
							next_hd.rd_tgl = ~hd.rd_tgl;
							next_lk.lstate = SEW_L_READ;
						end
						OP_WRITE, OP_WRITE_ALL: begin
							next_lk.lstate = SEW_L_DATA;
						end
						default: begin
							next_hd.cmd_tgl = ~hd.cmd_tgl;
							next_lk.lstate  = SEW_L_DONE;
						end
					endcase
				end
			end
			SEW_L_DATA: begin
				// Sixteen data bits, high bit first
				next_lk.data = {lk.data[`SEW_DW-2:0], serial_data_in};
				next_lk.cnt  = lk.cnt + 5'h01;
				if (lk.cnt == 5'(`SEW_DW - 1)) begin
					next_hd.data    = next_lk.data;
					next_hd.cmd_tgl = ~hd.cmd_tgl;
					next_lk.lstate  = SEW_L_DONE;
				end
			end
			SEW_L_READ: begin
				// Each edge advances the output by one bit; the 17th floats it
				next_hd.adv_tgl = ~hd.adv_tgl;
				next_lk.cnt     = lk.cnt + 5'h01;
				if (lk.cnt == 5'(`SEW_RD_EDGES - 1)) begin
					next_lk.lstate = SEW_L_DONE;
				end
			end
			SEW_L_DONE: begin
				// Extra edges ignored until select drops
				next_lk.lstate = SEW_L_DONE;
			end
			default: next_lk = '0;  // Unused state codes back to idle
		endcase
	end

	// Link control register
	always_ff @(posedge link_clk or negedge lrst_n) begin
		if (!lrst_n) begin
			lk <= '0;
		end else begin
			lk <= next_lk;
		end
	end

	// Hand-over register, survives select low
	always_ff @(posedge link_clk or negedge arst_n) begin
		if (!arst_n) begin
			hd <= '0;
		end else begin
			hd <= next_hd;
		end
	end

	// ----------------------------------------
	// Core domain
	// ----------------------------------------
	// Events from the second and third synchroniser stages
	assign ev      = c.s2 ^ c.s3;
	assign cs_on   = c.s2[`SEW_SY_CS];
	assign cs_rise = c.s2[`SEW_SY_CS] & ~c.s3[`SEW_SY_CS];
	assign cs_fall = ~c.s2[`SEW_SY_CS] & c.s3[`SEW_SY_CS];
	assign cmd_op  = sew_decode(hd.opc, hd.addr[`SEW_AW-1:`SEW_AW-2]);

	// Programming, read output and status
	always_comb begin
		next_c        = c;
		next_c.s1     = {hd.adv_tgl, hd.cmd_tgl, hd.rd_tgl, chip_select};
		next_c.s2     = c.s1;
		next_c.s3     = c.s2;
		next_c.mem_we = 1'b0;

		// Self-timed cycle, runs whatever select does
		if (c.busy) begin
			if (c.timer == '0) begin
				next_c.busy = 1'b0;
				if (!c.stat_show) begin
					next_c.stat_armed = 1'b0;
				end
			end else begin
				next_c.timer = c.timer - sew_tmr_t'(1);
			end
			if (c.sweep != 7'h00) begin
				next_c.mem_we   = 1'b1;
				next_c.sweep    = c.sweep - 7'h01;
				next_c.mem_addr = c.mem_addr + `SEW_AW'(1);
			end
		end

		// Commands from the link
		if (ev[`SEW_SY_CMD]) begin
			unique case (cmd_op)
				OP_EN:  next_c.prog_en = 1'b1;
				OP_DIS: next_c.prog_en = 1'b0;
				OP_WRITE, OP_ERASE, OP_ERASE_ALL, OP_WRITE_ALL: begin
					// Ignored unless enabled and idle
					if (c.prog_en && !c.busy) begin
						next_c.busy       = 1'b1;
						next_c.stat_armed = 1'b1;
						next_c.mem_we     = 1'b1;
						next_c.mem_addr   = hd.addr;
						next_c.mem_wdata  = hd.data;
						next_c.sweep      = 7'h00;
						next_c.timer      = sew_tmr_t'(WRITE_CYCLES - 1);
						if (cmd_op == OP_ERASE || cmd_op == OP_ERASE_ALL) begin
							next_c.mem_wdata = `SEW_ERASED;
							next_c.timer     = sew_tmr_t'(ERASE_CYCLES - 1);
						end
						if (cmd_op == OP_ERASE_ALL || cmd_op == OP_WRITE_ALL) begin
							next_c.mem_addr = '0;
							next_c.sweep    = 7'(`SEW_WORDS - 1);
							next_c.timer    = sew_tmr_t'(ALL_CYCLES - 1);
						end
					end
				end
				default: ;
			endcase
		end

		// Read output sequence
		unique case (c.rphase)
			R_IDLE: begin
				if (ev[`SEW_SY_RD] && cs_on && !c.busy) begin
					next_c.mem_addr = hd.addr;
					next_c.rphase   = R_FETCH;
					next_c.doe      = 1'b1;
					next_c.dout     = 1'b0;
				end
			end
			R_FETCH: next_c.rphase = R_LOAD;
			R_LOAD: begin
				next_c.shift  = mem_rdata;
				next_c.rcnt   = 5'h00;
				next_c.rphase = R_SHIFT;
			end
			R_SHIFT: begin
				// Bit held until the next link edge
				if (ev[`SEW_SY_ADV]) begin
					if (c.rcnt == 5'(`SEW_DW)) begin
						next_c.doe    = 1'b0;
						next_c.rphase = R_IDLE;
					end else begin
						next_c.dout  = c.shift[`SEW_DW-1];
						next_c.shift = {c.shift[`SEW_DW-2:0], 1'b0};
						next_c.rcnt  = c.rcnt + 5'h01;
					end
				end
			end
		endcase

		// Status on a fresh select after a program command
		if (cs_rise && c.stat_armed) begin
			next_c.stat_show = 1'b1;
			next_c.doe       = 1'b1;
			next_c.dout      = ~c.busy;  // No stale read bit
		end
		if (c.stat_show) begin
			next_c.dout = ~c.busy;
		end

		// Select low floats the pin and ends any output
		if (cs_fall) begin
			next_c.doe       = 1'b0;
			next_c.rphase    = R_IDLE;
			next_c.stat_show = 1'b0;
			// A command taken in this same cycle keeps status armed
			if (!next_c.busy) begin
				next_c.stat_armed = 1'b0;
			end
		end
	end

	// Core register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			c <= '0;
		end else begin
			c <= next_c;
		end
	end

	// ----------------------------------------
	// Array and pins
	// ----------------------------------------
	// Word array
	sew_mem #(
		.AW (`SEW_AW),
		.DW (`SEW_DW)
	) u_mem (
		.clk   (mclk),
		.we    (c.mem_we),
		.addr  (c.mem_addr),
		.wdata (c.mem_wdata),
		.rdata (mem_rdata)
	);

	// Pin drivers straight from core flops
	assign serial_data_out = c.dout;
	assign serial_data_oe  = c.doe;

endmodule

`default_nettype wire

// [sew_regs.svh]
// Constants of the serial EEPROM word engine.
// Assumes a 10 MHz system clock; included by package and engine.
`ifndef SEW_REGS_SVH
`define SEW_REGS_SVH

// ----------------------------------------
// Array shape
// ----------------------------------------
`define SEW_WORDS       64
`define SEW_AW          6
`define SEW_DW          16
`define SEW_ERASED      16'hFFFF

// ----------------------------------------
// Instruction framing
// ----------------------------------------
`define SEW_HEAD_BITS   8
`define SEW_RD_EDGES    17
`define SEW_OPC_SPECIAL 2'h0
`define SEW_OPC_WRITE   2'h1
`define SEW_OPC_READ    2'h2
`define SEW_OPC_ERASE   2'h3
`define SEW_SUB_DIS     2'h0
`define SEW_SUB_WRITE_ALL 2'h1
`define SEW_SUB_ERASE_ALL 2'h2
`define SEW_SUB_EN      2'h3

// ----------------------------------------
// Synchroniser bit positions
// ----------------------------------------
`define SEW_SY_CS       0
`define SEW_SY_RD       1
`define SEW_SY_CMD      2
`define SEW_SY_ADV      3

// ----------------------------------------
// Self-timed cycles
// ----------------------------------------
`define SEW_MCLK_MHZ    10
`define SEW_T_WRITE_US  2000
`define SEW_T_ERASE_US  1000
`define SEW_T_ALL_US    15000
`define SEW_WRITE_CYC   (`SEW_T_WRITE_US * `SEW_MCLK_MHZ)
`define SEW_ERASE_CYC   (`SEW_T_ERASE_US * `SEW_MCLK_MHZ)
`define SEW_ALL_CYC     (`SEW_T_ALL_US * `SEW_MCLK_MHZ)
`define SEW_TMR_W       18

`endif

// [sew_pkg.sv]
// Types and instruction decode of the serial EEPROM word engine.
// Assumes sew_regs.svh on the include path.
`default_nettype none
`include "sew_regs.svh"

package sew_pkg;

	typedef logic [`SEW_TMR_W-1:0] sew_tmr_t;

	typedef enum logic [2:0] {
		SEW_L_IDLE, SEW_L_HEAD, SEW_L_DATA, SEW_L_READ, SEW_L_DONE
	} sew_lstate_t;

	typedef enum logic [2:0] {
		OP_READ, OP_WRITE, OP_ERASE, OP_EN, OP_DIS, OP_ERASE_ALL, OP_WRITE_ALL
	} sew_op_t;

	typedef enum logic [1:0] {
		R_IDLE, R_FETCH, R_LOAD, R_SHIFT
	} sew_rphase_t;

	// Opcode and top address bits to an operation
	function automatic sew_op_t sew_decode(input logic [1:0] opc,
	                                       input logic [1:0] sub);
		sew_op_t op;
		op = OP_DIS;
		unique case (opc)
			`SEW_OPC_READ:  op = OP_READ;
			`SEW_OPC_WRITE: op = OP_WRITE;
			`SEW_OPC_ERASE: op = OP_ERASE;
			`SEW_OPC_SPECIAL: begin
				unique case (sub)
					`SEW_SUB_EN:   op = OP_EN;
					`SEW_SUB_DIS:  op = OP_DIS;
					`SEW_SUB_ERASE_ALL: op = OP_ERASE_ALL;
					`SEW_SUB_WRITE_ALL: op = OP_WRITE_ALL;
				endcase
			end
		endcase
		return op;
	endfunction

endpackage

`default_nettype wire

// [sew_mem.sv]
// Word array of the serial EEPROM word engine.
// Assumes one clock; read data registered, one cycle after the address.
`timescale 1ns/1ns
`default_nettype none

module sew_mem #(
	parameter int unsigned AW = 6,
	parameter int unsigned DW = 16
)(
	// Clock
	input  wire logic          clk,
	// Access
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);

	logic [DW-1:0] cells [0:(1<<AW)-1];

	// Write port and registered read
	always_ff @(posedge clk) begin
		if (we) begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end

endmodule

`default_nettype wire

// [sew_props.sv]
// Checker of the engine's data out pin, all on mclk.
// Assumes binding to the sew_engine ports.
`timescale 1ns/1ns
`default_nettype none

module sew_props (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Serial link
	input wire logic link_clk,
	input wire logic chip_select,
	input wire logic serial_data_in,
	// Data out pin
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Select held low past the synchroniser
	sequence s_deselect;
		$fell(chip_select) ##1 !chip_select [*4];
	endsequence
	// Pin enabled while select long high: a read
	sequence s_read_start;
		$rose(serial_data_oe) && $past(chip_select, 6);
	endsequence

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_reset_float: assert property ($rose(arst_n) |-> !serial_data_oe [*3])
		else $error("pin driven after reset");
	a_idle_quiet: assert property (!chip_select && !serial_data_oe |=> !serial_data_oe)
		else $error("pin driven while deselected");
	a_drive_needs_sel: assert property ($rose(serial_data_oe) |-> chip_select)
		else $error("pin enabled without select");
	a_dummy_zero: assert property (s_read_start |-> !serial_data_out)
		else $error("read did not lead with zero");
	a_deselect_release: assert property (s_deselect |-> !serial_data_oe)
		else $error("pin still driven after deselect");
	a_bit_stands: assert property ($rose(serial_data_oe) ##1 chip_select [*3] |-> serial_data_oe)
		else $error("output dropped while selected");
	a_ready_holds: assert property (
		!link_clk && serial_data_oe && serial_data_out ##1 !link_clk
		|-> !serial_data_oe || serial_data_out)
		else $error("output fell while clock low");
	a_status_sync: assert property (
		$rose(serial_data_oe) && !$past(chip_select, 6) |-> $past(chip_select, 2))
		else $error("status without select rise");
endmodule

bind sew_engine sew_props sew_props_inst (
	.mclk(mclk), .arst_n(arst_n), .link_clk(link_clk), .chip_select(chip_select),
	.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
	.serial_data_oe(serial_data_oe));
`default_nettype wire

// [sew_master.sv]
// Master controller model on the three-wire serial link.
// Assumes a pull-up resolves the data out pin when undriven.
`timescale 1ns/1ns
`default_nettype none
`include "sew_regs.svh"

module sew_master (
	// Link pins
	output logic      chip_select,
	output logic      link_clk,
	output logic      serial_data_in,
	// Resolved data out pin
	input  wire logic pin
);
	// Deselected, clock parked low
	initial begin
		chip_select = 1'b0;
		link_clk = 1'b0;
		serial_data_in = 1'b0;
	end

	// One bit, set with clock low, clock high for hi ns
	task automatic clk_bit(input logic b, input int hi);
		serial_data_in = b;
		#40 link_clk = 1'b1;
		#(hi) link_clk = 1'b0;
	endtask

	// Idle edges, start bit, n bits high first
	task automatic frame(input logic [23:0] bits, input int n, input int pre, input int hi);
		chip_select = 1'b1;
		for (int i = 0; i < pre; i++) clk_bit(1'b0, 40);
		clk_bit(1'b1, 40);
		for (int i = n - 1; i > 0; i--) clk_bit(bits[i], 40);
		clk_bit(bits[0], hi);
	endtask

	// Deselect with data line toggled, held low
	task automatic deselect();
		#40 chip_select = 1'b0;
		serial_data_in = ~serial_data_in;
		#500;
	endtask

	// Read, each bit sampled after a long clock high
	task automatic read_word(input logic [5:0] a, input int pre, input int nb,
	                         output logic dummy, output logic [15:0] w);
		w = 16'h0000;
		frame({16'h0000, `SEW_OPC_READ, a}, 8, pre, 500);
		dummy = pin;
		for (int i = 0; i < nb; i++) begin
			clk_bit(1'b0, 500);
			w = {w[14:0], pin};
		end
	endtask

	// Status look, data line left alone, bounded wait for ready
	task automatic status(output logic first, output int waited);
		chip_select = 1'b1;
		#500 first = pin;
		waited = 0;
		while (pin !== 1'b1 && waited < 1000) begin
			#100 waited++;
		end
		deselect();
	endtask
endmodule
`default_nettype wire

// [sew_engine_bench.sv]
// Self-checking bench of the serial EEPROM word engine.
// Assumes the master model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`include "sew_regs.svh"

module sew_engine_bench;
	localparam int WC = 100;
	localparam int EC = 80;
	localparam int AC = 200;
	localparam logic [7:0] C_EN = {`SEW_OPC_SPECIAL, `SEW_SUB_EN, 4'h0};
	localparam logic [7:0] C_DIS = {`SEW_OPC_SPECIAL, `SEW_SUB_DIS, 4'h0};
	localparam logic [7:0] C_ERASE_ALL = {`SEW_OPC_SPECIAL, `SEW_SUB_ERASE_ALL, 4'h0};
	localparam logic [7:0] C_WRITE_ALL = {`SEW_OPC_SPECIAL, `SEW_SUB_WRITE_ALL, 4'h0};

	typedef struct { logic [5:0] a; logic [15:0] d; logic [15:0] q; } sew_row_t;
	sew_row_t rows [4] = '{'{6'h00, 16'h8001, 16'h8001}, '{6'h3F, 16'h7FFE, 16'h7FFE},
	                       '{6'h15, 16'h0000, 16'h0000}, '{6'h2A, 16'h5AA5, 16'h5AA5}};

	logic        mclk = 1'b0;
	logic        arst_n;
	logic        dummy;
	logic [15:0] word;
	wire logic   link_clk, chip_select, serial_data_in, serial_data_out, serial_data_oe, pin;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;

	// Pull-up on the data out pin
	assign pin = serial_data_oe ? serial_data_out : 1'b1;

	// Clock
	initial begin
		forever #50 mclk = ~mclk;
	end

	sew_engine #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC), .ALL_CYCLES(AC)) sew_engine_inst (
		.mclk(mclk), .arst_n(arst_n), .link_clk(link_clk), .chip_select(chip_select),
		.serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
		.serial_data_oe(serial_data_oe));
	sew_master sew_master_inst (.chip_select(chip_select), .link_clk(link_clk),
		.serial_data_in(serial_data_in), .pin(pin));

	task automatic finish_test();
		$display("Errors %0d of %0d checks", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Command without status look
	task automatic cmd(input logic [23:0] bits, input int n);
		sew_master_inst.frame(bits, n, 0, 40);
		sew_master_inst.deselect();
	endtask

	// Command then status; cyc of 0 means refused
	task automatic prog(input logic [23:0] bits, input int n, input int cyc);
		logic first;
		int   waited;
		cmd(bits, n);
		sew_master_inst.status(first, waited);
		expect_eq({15'h0000, first}, {15'h0000, cyc == 0}, "status level");
		expect_eq({15'h0000, cyc == 0 ? waited == 0 : (waited >= cyc - 30 && waited <= cyc)},
			16'h0001, "busy span");
	endtask

	// Full read, then the release edge
	task automatic rd(input logic [5:0] a, input int pre, input logic [15:0] exp);
		logic        d0;
		logic [15:0] w;
		sew_master_inst.read_word(a, pre, 16, d0, w);
		expect_eq({15'h0000, d0}, 16'h0000, "dummy bit");
		expect_eq(w, exp, "read word");
		sew_master_inst.clk_bit(1'b0, 500);
		expect_eq({15'h0000, serial_data_oe}, 16'h0000, "float after lsb");
		sew_master_inst.deselect();
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("MISMATCH %0t timeout", $time);
			finish_test();
		end
	end

	// Main sequence
	initial begin
		arst_n = 1'b0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		expect_eq({15'h0000, serial_data_oe}, 16'h0000, "idle pin");
		prog(C_ERASE_ALL, 8, 0);
		cmd(C_EN, 8);
		prog(C_ERASE_ALL, 8, AC);
		cmd(C_DIS, 8);
		prog({`SEW_OPC_WRITE, 6'h05, 16'h1234}, 24, 0);
		rd(6'h05, 0, 16'hFFFF);
		cmd(C_EN, 8);
		prog({C_WRITE_ALL, 16'hA5A5}, 24, AC);
		rd(6'h00, 0, 16'hA5A5);
		rd(6'h3F, 5, 16'hA5A5);
		for (int i = 0; i < 4; i++) begin
			prog({`SEW_OPC_WRITE, rows[i].a, rows[i].d}, 24, WC);
			rd(rows[i].a, 0, rows[i].q);
		end
		prog({`SEW_OPC_ERASE, 6'h15}, 8, EC);
		rd(6'h15, 0, 16'hFFFF);
		prog({`SEW_OPC_WRITE, 6'h2A, 4'h0}, 12, 0);
		rd(6'h2A, 0, 16'h5AA5);
		cmd({`SEW_OPC_WRITE, 6'h3F, 16'h1234}, 24);
		#(WC * 100 + 2000);
		rd(6'h3F, 0, 16'h1234);
		sew_master_inst.read_word(6'h00, 0, 3, dummy, word);
		sew_master_inst.deselect();
		expect_eq(word, 16'h0004, "aborted read bits");
		expect_eq({15'h0000, serial_data_oe}, 16'h0000, "float on deselect");
		cmd(C_DIS, 8);
		prog({`SEW_OPC_WRITE, 6'h00, 16'h0F0F}, 24, 0);
		rd(6'h00, 0, 16'h8001);
		// Mid-run reset must drop an enable given just before it
		cmd(C_EN, 8);
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		expect_eq({15'h0000, serial_data_oe}, 16'h0000, "idle after reset");
		prog({`SEW_OPC_WRITE, 6'h00, 16'h0F0F}, 24, 0);
		rd(6'h00, 0, 16'h8001);
		finish_test();
	end
endmodule
`default_nettype wire
